// File: rtl/ims_pkg.sv
// constants, register map and state type of the i2c master sequencer
package ims_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_DATA = 5'h08;
	localparam logic [4:0] OFS_RELOAD = 5'h0c;
	localparam logic [4:0] OFS_CONFIG = 5'h10;
	localparam logic [4:0] OFS_FLAGS = 5'h14;
	// control_reg_two fields
	localparam int CTRL_START = 0;
	localparam int CTRL_RESTART = 1;
	localparam int CTRL_ACK = 6;
	localparam int CTRL_LOCK_W = 5;
	// status_reg fields
	localparam int STAT_BF = 0;
	localparam int STAT_START = 3;
	// config and flag fields
	localparam int CFG_EN = 0;
	localparam int FLG_IRQ = 0;
	localparam int FLG_BCL = 1;
	localparam int FLG_WRITE_COLLISION_FLAG = 2;
	// reset values
	localparam logic [6:0] RELOAD_RST = 7'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic CFG_EN_RST = 1'b0;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing: clk runs at twice the instruction rate
	localparam int CLK_NS = 50;
	localparam int TCY_NS = 100;
	localparam int WRITE_COLLISION_FLAG_TCY = 2;
	localparam logic [2:0] WRITE_COLLISION_FLAG_CYC = 3'(WRITE_COLLISION_FLAG_TCY * TCY_NS / CLK_NS);
	// bit positions within a byte frame
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	typedef enum logic [3:0] {
		S_IDLE,
		S_ST_WAIT,
		S_ST_HOLD,
		S_RS_LWAIT,
		S_RS_LCNT,
		S_RS_HWAIT,
		S_RS_HCNT,
		S_RS_SCNT,
		S_TX_LOW,
		S_TX_HWAIT,
		S_TX_HIGH
	} ims_state_t;
endpackage

// File: rtl/ims_sync.sv
// two-flop synchroniser for the scl and sda pin inputs
`timescale 1ns/1ps
`default_nettype none
module ims_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] din,
	output logic [1:0] dout
);
	logic [1:0] meta_r;

	// released lines idle high, so reset to ones
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= 2'h3;
			dout <= 2'h3;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule
`default_nettype wire

// File: rtl/ims_brg.sv
// bit-rate down counter: load, count to zero, hold
`timescale 1ns/1ps
`default_nettype none
module ims_brg (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ld,
	input wire logic [6:0] ld_val,
	input wire logic run,
	output logic zero
);
	logic [6:0] cnt_r;

	// one step per clk, i.e. two per instruction cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 7'h00;
		end else if (ld) begin
			cnt_r <= ld_val;
		end else if (run && cnt_r != 7'h00) begin
			cnt_r <= cnt_r - 7'h01;
		end
	end

	assign zero = (cnt_r == 7'h00);
endmodule
`default_nettype wire

// File: rtl/ims_seq_top.sv
// i2c master start, restart and transmit sequencer with axi4-lite regs
//
// Behaviour
// - counter reloads from reload bits 6:0, steps twice per cycle, stops at zero
// - one scl period spans two counter rollovers
// - released scl pauses the counter until sampled high, then reloads
// - start with both lines high counts; at timeout drive sda low, flag start
// - after sda low count again, then clear start enable, keep sda low
// - a low line at start or scl low early flags bus collision, idle
// - buffer writes during a start are dropped and set write collision
// - control bits 4:0 writes ignored while start or restart runs
// - restart from idle pulls scl low, counts reload 5:0 with sda released
// - then release scl, both high one period, sda low one period, done
// - start status set on seen start; irq flag waits for timeout
// - restart request while another event runs has no effect
// - restart collides if sda low as scl rises or scl falls early
// - buffer writes during a restart are dropped and set write collision
// - buffer write sets full flag, starts counter, shifts bits per scl
// - eighth falling edge releases sda; ninth samples ack into ctrl bit 6
// - after ninth clock set irq, stop, hold scl low; full already cleared after eighth
// - full flag set on buffer write, cleared after eight bits shifted
// - write during transmit sets collision; buffer updated only within 2 cycles
`timescale 1ns/1ps
`default_nettype none
module ims_seq_top (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [4:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [4:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE
);
	////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	logic aw_got_r, w_got_r;
	logic [4:0] waddr_r, raddr;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic wr_en, wr_ok, rd_ok;
	logic [31:0] rd_val;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= 5'h00;
			wdata_r <= 32'h0;
			wstrb0_r <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= ims_pkg::RESP_OKAY;
		end else begin
			AWREADY <= AWVALID && !AWREADY && !aw_got_r && !BVALID;
			WREADY <= WVALID && !WREADY && !w_got_r && !BVALID;
			if (AWVALID && AWREADY) begin
				aw_got_r <= 1'b1;
				waddr_r <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_got_r <= 1'b1;
				wdata_r <= WDATA;
				wstrb0_r <= WSTRB[0];
			end
			if (wr_en) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wr_ok ? ims_pkg::RESP_OKAY : ims_pkg::RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	assign wr_en = aw_got_r && w_got_r && !BVALID;
	assign wr_ok = (waddr_r <= ims_pkg::OFS_FLAGS) && (waddr_r[1:0] == 2'h0);
	assign raddr = ARADDR;
	assign rd_ok = (raddr <= ims_pkg::OFS_FLAGS) && (raddr[1:0] == 2'h0);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0;
			RRESP <= ims_pkg::RESP_OKAY;
		end else begin
			ARREADY <= ARVALID && !ARREADY && !RVALID;
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA <= rd_ok ? rd_val : 32'h0;
				RRESP <= rd_ok ? ims_pkg::RESP_OKAY : ims_pkg::RESP_SLVERR;
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// byte lane 0 carries every writable field
	logic wr_lane, wr_ctrl, wr_data, wr_reload, wr_cfg, wr_flags;
	assign wr_lane = wr_en && wstrb0_r;
	assign wr_ctrl = wr_lane && waddr_r == ims_pkg::OFS_CTRL;
	assign wr_data = wr_lane && waddr_r == ims_pkg::OFS_DATA;
	assign wr_reload = wr_lane && waddr_r == ims_pkg::OFS_RELOAD;
	assign wr_cfg = wr_lane && waddr_r == ims_pkg::OFS_CONFIG;
	assign wr_flags = wr_lane && waddr_r == ims_pkg::OFS_FLAGS;

	////////////////////////////////////////////////////////////////////
	// registers and pin sampling
	ims_pkg::ims_state_t state_r, state_nxt;
	logic [6:0] reload_r;
	logic [7:0] buf_r, buf_nxt, shift_r, shift_nxt;
	logic en_r, sen_r, sen_nxt, restart_gen_enable_r, restart_gen_enable_nxt, bf_r, bf_nxt;
	logic ack_r, ack_nxt, start_det_r, sda_d_r;
	logic irq_r, bcl_r, write_collision_flag_r, irq_set, bcl_set, write_collision_flag_set;
	logic scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [2:0] since_wr_r;
	logic [1:0] pins_s;
	logic scl_s, sda_s, ld, run, tmo;
	logic [6:0] ld_val;
	logic [7:0] ctrl_val;

	ims_sync u_sync (
		.clk(CLK),
		.rstn(RSTN),
		.din({SCL_I, SDA_I}),
		.dout(pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	ims_brg u_brg (
		.clk(CLK),
		.rstn(RSTN),
		.ld(ld),
		.ld_val(ld_val),
		.run(run),
		.zero(tmo)
	);

	// counter steps only in states that time a rollover
	assign run = state_r == ims_pkg::S_ST_WAIT
		|| state_r == ims_pkg::S_ST_HOLD
		|| state_r == ims_pkg::S_RS_LCNT
		|| state_r == ims_pkg::S_RS_HCNT
		|| state_r == ims_pkg::S_RS_SCNT
		|| state_r == ims_pkg::S_TX_LOW
		|| state_r == ims_pkg::S_TX_HIGH;

	logic in_start, in_tx;
	assign in_start = state_r == ims_pkg::S_ST_WAIT
		|| state_r == ims_pkg::S_ST_HOLD
		|| state_r == ims_pkg::S_RS_LWAIT
		|| state_r == ims_pkg::S_RS_LCNT
		|| state_r == ims_pkg::S_RS_HWAIT
		|| state_r == ims_pkg::S_RS_HCNT
		|| state_r == ims_pkg::S_RS_SCNT;
	assign in_tx = state_r == ims_pkg::S_TX_LOW
		|| state_r == ims_pkg::S_TX_HWAIT
		|| state_r == ims_pkg::S_TX_HIGH;

	////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_nxt = state_r;
		scl_low_nxt = scl_low_r;
		sda_low_nxt = sda_low_r;
		sen_nxt = sen_r;
		restart_gen_enable_nxt = restart_gen_enable_r;
		bf_nxt = bf_r;
		bit_nxt = bit_r;
		shift_nxt = shift_r;
		buf_nxt = buf_r;
		ack_nxt = ack_r;
		irq_set = 1'b0;
		bcl_set = 1'b0;
		write_collision_flag_set = 1'b0;
		ld = 1'b0;
		ld_val = reload_r;
		unique case (state_r)
			ims_pkg::S_IDLE: begin
				if (wr_data) begin
					buf_nxt = low_byte(wdata_r);
					shift_nxt = low_byte(wdata_r);
					bf_nxt = 1'b1;
					bit_nxt = 4'h0;
					// sda keeps its level until scl is already low
					scl_low_nxt = 1'b1;
					ld = 1'b1;
					state_nxt = ims_pkg::S_TX_LOW;
				end else if (wr_ctrl && wdata_r[ims_pkg::CTRL_START]) begin
					sen_nxt = 1'b1;
					if (scl_s && sda_s) begin
						ld = 1'b1;
						state_nxt = ims_pkg::S_ST_WAIT;
					end else begin
						bcl_set = 1'b1;
						sen_nxt = 1'b0;
					end
				end else if (wr_ctrl && wdata_r[ims_pkg::CTRL_RESTART]) begin
					restart_gen_enable_nxt = 1'b1;
					scl_low_nxt = 1'b1;
					state_nxt = ims_pkg::S_RS_LWAIT;
				end
			end
			ims_pkg::S_ST_WAIT: begin
				if (!scl_s) begin
					bcl_set = 1'b1;
				end else if (tmo) begin
					if (sda_s) begin
						sda_low_nxt = 1'b1;
						ld = 1'b1;
						state_nxt = ims_pkg::S_ST_HOLD;
					end else begin
						bcl_set = 1'b1;
					end
				end
			end
			ims_pkg::S_ST_HOLD: begin
				if (tmo) begin
					sen_nxt = 1'b0;
					irq_set = 1'b1;
					state_nxt = ims_pkg::S_IDLE;
				end
			end
			ims_pkg::S_RS_LWAIT: begin
				if (!scl_s) begin
					ld = 1'b1;
					ld_val = {1'b0, reload_r[5:0]};
					sda_low_nxt = 1'b0;
					state_nxt = ims_pkg::S_RS_LCNT;
				end
			end
			ims_pkg::S_RS_LCNT: begin
				if (tmo) begin
					if (sda_s) begin
						scl_low_nxt = 1'b0;
						state_nxt = ims_pkg::S_RS_HWAIT;
					end else begin
						bcl_set = 1'b1;
					end
				end
			end
			ims_pkg::S_RS_HWAIT: begin
				if (scl_s) begin
					if (!sda_s) begin
						bcl_set = 1'b1;
					end else begin
						ld = 1'b1;
						state_nxt = ims_pkg::S_RS_HCNT;
					end
				end
			end
			ims_pkg::S_RS_HCNT: begin
				if (!scl_s || !sda_s) begin
					bcl_set = 1'b1;
				end else if (tmo) begin
					sda_low_nxt = 1'b1;
					ld = 1'b1;
					state_nxt = ims_pkg::S_RS_SCNT;
				end
			end
			ims_pkg::S_RS_SCNT: begin
				if (tmo) begin
					restart_gen_enable_nxt = 1'b0;
					irq_set = 1'b1;
					state_nxt = ims_pkg::S_IDLE;
				end
			end
			ims_pkg::S_TX_LOW: begin
				// bits move one clk after scl falls, for hold time on sda
				sda_low_nxt = !shift_r[7]
					&& bit_r != ims_pkg::ACK_BIT;
				if (tmo) begin
					scl_low_nxt = 1'b0;
					state_nxt = ims_pkg::S_TX_HWAIT;
				end
			end
			ims_pkg::S_TX_HWAIT: begin
				if (scl_s) begin
					ld = 1'b1;
					state_nxt = ims_pkg::S_TX_HIGH;
				end
			end
			ims_pkg::S_TX_HIGH: begin
				if (tmo) begin
					scl_low_nxt = 1'b1; // falling edge
					bit_nxt = bit_r + 4'h1;
					if (bit_r == ims_pkg::ACK_BIT) begin
						ack_nxt = sda_s;
						irq_set = 1'b1;
						state_nxt = ims_pkg::S_IDLE;
					end else begin
						// shift before the next low phase
						shift_nxt = {shift_r[6:0], 1'b0};
						if (bit_r == ims_pkg::LAST_DATA_BIT) begin
							bf_nxt = 1'b0;
						end
						ld = 1'b1;
						state_nxt = ims_pkg::S_TX_LOW;
					end
				end
			end
		endcase
		// a dropped write in a sequence must still raise the flag
		if (wr_data && in_start) begin
			write_collision_flag_set = 1'b1;
		end
		if (wr_data && in_tx) begin
			write_collision_flag_set = 1'b1;
			if (since_wr_r < ims_pkg::WRITE_COLLISION_FLAG_CYC) begin
				// early rewrite corrupts the byte in flight
				buf_nxt = low_byte(wdata_r);
				shift_nxt = low_byte(wdata_r);
			end
		end
		if (bcl_set) begin
			sen_nxt = 1'b0;
			restart_gen_enable_nxt = 1'b0;
			scl_low_nxt = 1'b0;
			sda_low_nxt = 1'b0;
			state_nxt = ims_pkg::S_IDLE;
		end
		if (!en_r) begin
			sen_nxt = 1'b0;
			restart_gen_enable_nxt = 1'b0;
			bf_nxt = 1'b0;
			scl_low_nxt = 1'b0;
			sda_low_nxt = 1'b0;
			state_nxt = ims_pkg::S_IDLE;
		end
	end

	function automatic logic [7:0] low_byte(input logic [31:0] d);
		low_byte = d[7:0];
	endfunction

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= ims_pkg::S_IDLE;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
			sen_r <= 1'b0;
			restart_gen_enable_r <= 1'b0;
			bf_r <= 1'b0;
			bit_r <= 4'h0;
			shift_r <= ims_pkg::DATA_RST;
			buf_r <= ims_pkg::DATA_RST;
			ack_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			scl_low_r <= scl_low_nxt;
			sda_low_r <= sda_low_nxt;
			sen_r <= sen_nxt;
			restart_gen_enable_r <= restart_gen_enable_nxt;
			bf_r <= bf_nxt;
			bit_r <= bit_nxt;
			shift_r <= shift_nxt;
			buf_r <= buf_nxt;
			ack_r <= ack_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// software registers, flags and line monitor
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			reload_r <= ims_pkg::RELOAD_RST;
			en_r <= ims_pkg::CFG_EN_RST;
			since_wr_r <= ims_pkg::WRITE_COLLISION_FLAG_CYC;
		end else begin
			if (wr_reload) begin
				reload_r <= wdata_r[6:0];
			end
			if (wr_cfg) begin
				en_r <= wdata_r[ims_pkg::CFG_EN];
			end
			if (wr_data) begin
				since_wr_r <= 3'h0;
			end else if (since_wr_r < ims_pkg::WRITE_COLLISION_FLAG_CYC) begin
				since_wr_r <= since_wr_r + 3'h1;
			end
		end
	end

	// set wins over a same-cycle write-one-to-clear
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_r <= 1'b0;
			bcl_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
		end else begin
			irq_r <= irq_set
				|| (irq_r && !(wr_flags && wdata_r[ims_pkg::FLG_IRQ]));
			bcl_r <= bcl_set
				|| (bcl_r && !(wr_flags && wdata_r[ims_pkg::FLG_BCL]));
			write_collision_flag_r <= write_collision_flag_set
				|| (write_collision_flag_r && !(wr_flags && wdata_r[ims_pkg::FLG_WRITE_COLLISION_FLAG]));
		end
	end

	// start seen on the lines: sda falling while scl high
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sda_d_r <= 1'b1;
			start_det_r <= 1'b0;
		end else begin
			sda_d_r <= sda_s;
			if (!en_r) begin
				start_det_r <= 1'b0;
			end else if (sda_d_r && !sda_s && scl_s) begin
				start_det_r <= 1'b1;
			end
		end
	end

	// control bits 4:0 are self-managed; writes there never queue
	assign ctrl_val = {1'b0, ack_r, 4'h0, restart_gen_enable_r, sen_r};

	always_comb begin
		rd_val = 32'h0;
		unique case (raddr)
			ims_pkg::OFS_CTRL: rd_val[7:0] = ctrl_val;
			ims_pkg::OFS_STATUS: begin
				rd_val[ims_pkg::STAT_BF] = bf_r;
				rd_val[ims_pkg::STAT_START] = start_det_r;
			end
			ims_pkg::OFS_DATA: rd_val[7:0] = buf_r;
			ims_pkg::OFS_RELOAD: rd_val[6:0] = reload_r;
			ims_pkg::OFS_CONFIG: rd_val[ims_pkg::CFG_EN] = en_r;
			ims_pkg::OFS_FLAGS: rd_val[2:0] = {write_collision_flag_r, bcl_r, irq_r};
			default: rd_val = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// open-drain pins: value always low, enable pulls the line
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
			SCL_OE <= 1'b0;
			SDA_OE <= 1'b0;
		end else begin
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
			SCL_OE <= scl_low_nxt;
			SDA_OE <= sda_low_nxt;
		end
	end
endmodule
`default_nettype wire

// File: tb/ims_checker.sv
// concurrent checks on the i2c sequencer top ports
`timescale 1ns/1ps
`default_nettype none
module ims_checker (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [4:0] AWADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic SCL_I,
	input wire logic SCL_O,
	input wire logic SCL_OE,
	input wire logic SDA_O,
	input wire logic SDA_OE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	logic [6:0] rl_r;
	logic [7:0] hi_r;
	logic [7:0] lo_r;
	logic aw_w;
	assign aw_w = AWVALID && AWREADY && WVALID && WREADY;
	// reload shadow snooped from the bus; phase counters saturate
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rl_r <= 7'h00;
			hi_r <= 8'h00;
			lo_r <= 8'h00;
		end else begin
			if (aw_w && AWADDR == ims_pkg::OFS_RELOAD && WSTRB[0])
				rl_r <= WDATA[6:0];
			hi_r <= (SCL_I && !SCL_OE) ? hi_r + 8'(hi_r != 8'hff) : 8'h00;
			lo_r <= SCL_OE ? lo_r + 8'(lo_r != 8'hff) : 8'h00;
		end
	end
	sequence wr_take;
		aw_w;
	endsequence
	sequence rd_take;
		ARVALID && ARREADY;
	endsequence
	od_drive_a: assert property (!SCL_O && !SDA_O)
		else $error("line driven high");
	rst_release_a: assert property (@(posedge CLK) disable iff (1'b0)
		!RSTN |-> !SCL_OE && !SDA_OE) else $error("line held in reset");
	hi_time_a: assert property ($rose(SCL_OE) |-> hi_r > rl_r)
		else $error("scl high phase short");
	lo_time_a: assert property ($fell(SCL_OE) |-> lo_r > {1'b0, rl_r[5:0]})
		else $error("scl low phase short");
	start_edge_a: assert property ($rose(SDA_OE) && !SCL_OE |->
		SCL_I && $past(SCL_I, 4)) else $error("sda pulled with scl low");
	wr_answer_a: assert property (wr_take |-> ##[1:2] BVALID)
		else $error("no write response");
	rd_answer_a: assert property (rd_take |-> ##[0:2] RVALID)
		else $error("no read data");
	b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped");
	r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped");
endmodule
bind ims_seq_top ims_checker chk (.*);
`default_nettype wire

// File: tb/ims_slave.sv
// i2c slave model: shifts in bytes, acks or not, stretches scl low
`timescale 1ns/1ps
`default_nettype none
module ims_slave (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	input wire logic [3:0] stretch,
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic [3:0] n = 4'h0;
	logic [3:0] hold = 4'h0;
	initial sda_pull = 1'b0;
	initial rx_stb = 1'b0;
	initial rx_byte = 8'h00;
	// stretching outlasts the master's low phase to force a pause
	assign scl_pull = hold != 4'h0;
	always @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		rx_stb <= 1'b0;
		if (scl_q && scl && sda_q && !sda)
			n <= 4'h0;
		else if (scl && !scl_q) begin
			if (n < 4'h8)
				rx_byte <= {rx_byte[6:0], sda};
			rx_stb <= n == 4'h7;
			n <= n + 4'h1;
		end else if (!scl && scl_q) begin
			hold <= stretch;
			sda_pull <= n == 4'h8 && !nack;
			if (n == 4'h9)
				n <= 4'h0;
		end else if (hold != 4'h0)
			hold <= hold - 4'h1;
	end
endmodule
`default_nettype wire

// File: tb/ims_seq_top_tb_top.sv
// self-checking bench for the i2c start, restart and transmit sequencer
`timescale 1ns/1ps
`default_nettype none
module ims_seq_top_tb_top;
	localparam logic [4:0] a_ctl = ims_pkg::OFS_CTRL;
	localparam logic [4:0] a_sts = ims_pkg::OFS_STATUS;
	localparam logic [4:0] a_dat = ims_pkg::OFS_DATA;
	localparam logic [4:0] a_flg = ims_pkg::OFS_FLAGS;
	localparam logic [1:0] ok = ims_pkg::RESP_OKAY;
	localparam logic [33:0] all = 34'h3_ffff_ffff;
	logic CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [4:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, got;
	logic [3:0] WSTRB, stretch;
	logic [1:0] BRESP, RRESP;
	logic SCL_O, SCL_OE, SDA_O, SDA_OE, scl_w, sda_w;
	logic nack, jam, scl_p, sda_p, rx_stb;
	logic [7:0] rx_byte, b;
	logic [33:0] rq[$], mq[$];
	logic [1:0] bq[$];
	logic [7:0] xq[$];
	int fails, checked, seed, i;
	// pull-ups: a line is high unless someone pulls it
	assign scl_w = !SCL_OE && !scl_p;
	assign sda_w = !SDA_OE && !sda_p && !jam;
	ims_seq_top dut (.CLK(CLK), .RSTN(RSTN), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .SCL_I(scl_w), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
		.SDA_I(sda_w), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
	ims_slave sl (.clk(CLK), .scl(scl_w), .sda(sda_w), .nack(nack),
		.stretch(stretch), .scl_pull(scl_p), .sda_pull(sda_p),
		.rx_byte(rx_byte), .rx_stb(rx_stb));
	always #25 CLK = ~CLK;
	task automatic bad(input string s, input logic [33:0] e, input logic [33:0] g);
		fails++;
		$display("wrong value %s expected %h seen %h", s, e, g);
	endtask
	task automatic end_of_test();
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge CLK) begin
		if (RVALID && RREADY && rq.size() > 0) begin
			checked++;
			if ((({RRESP, RDATA} ^ rq[0]) & mq[0]) !== 34'h0)
				bad("read", rq[0], {RRESP, RDATA});
			rq.delete(0);
			mq.delete(0);
		end
		if (BVALID && BREADY && bq.size() > 0) begin
			checked++;
			if (BRESP !== bq[0])
				bad("bresp", 34'(bq[0]), 34'(BRESP));
			bq.delete(0);
		end
		if (rx_stb === 1'b1 && xq.size() > 0) begin
			checked++;
			if (rx_byte !== xq[0])
				bad("byte", 34'(xq[0]), 34'(rx_byte));
			xq.delete(0);
		end
	end
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw, w;
		int k;
		bq.push_back(r);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		k = 0;
		while ((aw || w) && k < 99) begin
			@(posedge CLK);
			k++;
			aw = aw && AWREADY !== 1'b1;
			w = w && WREADY !== 1'b1;
			AWVALID <= aw;
			WVALID <= w;
		end
		BREADY <= 1'b1;
		do begin
			@(posedge CLK);
			k++;
		end while (BVALID !== 1'b1 && k < 199);
		BREADY <= 1'b0;
		if (BVALID !== 1'b1)
			bad("bvalid", 34'h1, 34'(BVALID));
	endtask
	task automatic rd(input logic [4:0] a, input logic [33:0] e, input logic [33:0] m);
		int k;
		rq.push_back(e);
		mq.push_back(m);
		ARADDR <= a;
		ARVALID <= 1'b1;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while (ARREADY !== 1'b1 && k < 99);
		ARVALID <= 1'b0;
		RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			k++;
		end while (RVALID !== 1'b1 && k < 199);
		got = RDATA;
		RREADY <= 1'b0;
		if (RVALID !== 1'b1)
			bad("rvalid", 34'h1, 34'(RVALID));
	endtask
	task automatic poll(input logic [4:0] a, input int p, input logic v);
		int k;
		k = 0;
		do begin
			rd(a, 34'h0, 34'h0);
			k++;
		end while (got[p] !== v && k < 300);
		checked++;
		if (got[p] !== v)
			bad("poll", 34'(v), 34'(got[p]));
	endtask
	task automatic see(input logic g, input logic e);
		checked++;
		if (g !== e)
			bad("line", 34'(e), 34'(g));
	endtask
	initial begin
		#2000000;
		fails++;
		end_of_test();
	end
	initial begin
		{CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, nack, jam} = '0;
		{AWADDR, ARADDR, WDATA, stretch} = '0;
		WSTRB = 4'hf;
		seed = 41020;
		repeat (2) @(posedge CLK);
		RSTN <= 1'b1;
		@(posedge CLK);
		for (i = 0; i < 6; i++)
			rd(5'(i * 4), 34'h0, all);
		rd(5'h18, {ims_pkg::RESP_SLVERR, 32'h0}, all);
		wr(5'h18, 32'h1, ims_pkg::RESP_SLVERR);
		wr(ims_pkg::OFS_RELOAD, 32'h90, ok);
		rd(ims_pkg::OFS_RELOAD, 34'h10, all);
		wr(ims_pkg::OFS_CONFIG, 32'h1, ok);
		wr(a_ctl, 32'h1, ok);
		wr(a_dat, 32'h5a, ok);
		wr(a_ctl, 32'h2, ok);
		poll(a_ctl, ims_pkg::CTRL_START, 1'b0);
		rd(a_ctl, 34'h0, {2'h3, 32'h3});
		rd(a_sts, 34'h8, {2'h3, 32'h9});
		rd(a_flg, 34'h5, all);
		rd(a_dat, 34'h0, all);
		see(sda_w, 1'b0);
		see(scl_w, 1'b1);
		wr(a_flg, 32'h7, ok);
		rd(a_flg, 34'h0, all);
		wr(ims_pkg::OFS_RELOAD, 32'h3, ok);
		// second byte is refused by the slave and stretched
		for (i = 0; i < 2; i++) begin
			nack <= i[0];
			stretch <= i[0] ? 4'h9 : 4'h0;
			b = 8'($random(seed));
			xq.push_back(b);
			wr(a_dat, {24'h0, b}, ok);
			rd(a_sts, 34'h1, {2'h3, 32'h1});
			wr(a_dat, {24'h0, ~b}, ok);
			rd(a_flg, 34'h4, {2'h3, 32'h4});
			rd(a_dat, {26'h0, b}, {2'h3, 32'hff});
			poll(a_flg, ims_pkg::FLG_IRQ, 1'b1);
			rd(a_ctl, 34'(i) << ims_pkg::CTRL_ACK, {2'h3, 32'h40});
			rd(a_sts, 34'h0, {2'h3, 32'h1});
			see(scl_w, 1'b0);
			see(sda_w, 1'b1);
			wr(a_flg, 32'h7, ok);
		end
		wr(a_ctl, 32'h2, ok);
		wr(a_dat, 32'h33, ok);
		poll(a_ctl, ims_pkg::CTRL_RESTART, 1'b0);
		rd(a_flg, 34'h5, all);
		rd(a_dat, {26'h0, b}, {2'h3, 32'hff});
		see(sda_w, 1'b0);
		wr(a_flg, 32'h7, ok);
		// address byte straight after the restart, refused by the slave
		b = 8'($random(seed));
		xq.push_back(b);
		wr(a_dat, {24'h0, b}, ok);
		poll(a_flg, ims_pkg::FLG_IRQ, 1'b1);
		rd(a_ctl, 34'h40, {2'h3, 32'h40});
		wr(a_flg, 32'h7, ok);
		// a line held low by another party aborts start and restart
		for (i = 0; i < 2; i++) begin
			jam <= 1'b1;
			wr(a_ctl, 32'(1 << i), ok);
			poll(a_flg, ims_pkg::FLG_BCL, 1'b1);
			rd(a_ctl, 34'h0, {2'h3, 32'h3});
			jam <= 1'b0;
			wr(a_flg, 32'h7, ok);
		end
		stretch <= 4'h0;
		wr(a_dat, 32'hc3, ok);
		@(posedge CLK);
		repeat (99)
			if (scl_w !== 1'b1)
				@(posedge CLK);
		see(scl_w, 1'b1);
		wr(ims_pkg::OFS_CONFIG, 32'h0, ok);
		rd(a_sts, 34'h0, all);
		rd(a_ctl, 34'h0, {2'h3, 32'h3});
		see(scl_w, 1'b1);
		see(sda_w, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
